// file: rtl/serial_port.sv
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module serial_port
  import uart_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxd,
  input wire logic cts_in,
  input wire logic dsr_in,
  output logic txd,
  output logic rts_out,
  output logic cts_out,
  output logic dtr_out,
  output logic drv_en,
  output logic [1:0] line_mode
);
  logic [10:0] ctrl_ff;
  logic [DIV_W-1:0] baud_ff;
  logic [15:0] flush_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [7:0] mem [0:(1 << BUF_AW) - 1];
  logic [BUF_AW-1:0] wptr_ff, rptr_ff;
  logic [BUF_AW:0] cnt_ff;
  logic rel_ff;
  logic [19:0] pre_ff;
  logic [15:0] ms_ff;
  tx_state_t tx_state_ff, nxt_tx_state;
  rx_state_t rx_state_ff, nxt_rx_state;
  logic [7:0] sh_ff, tbyte_ff, rsh_ff, rx_data_ff;
  logic [2:0] tbit_ff, rbit_ff;
  logic txd_ff, rpar_ff, rx_valid_ff, perr_ff, ferr_ff, ovr_ff, paused_ff, xoff_sent_ff;
  logic rts_ff, cts_ff, dtr_ff, drv_ff;
  logic [2:0] sync_q;

  bit_sync #(.W(3), .RST(3'b001)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d({dsr_in, cts_in, rxd}),
    .q(sync_q)
  );
  wire rxd_s = sync_q[0];
  wire cts_s = sync_q[1];
  wire dsr_s = sync_q[2];

  // Configuration decode.
  wire iface_t iface = iface_t'(ctrl_ff[CTRL_IFACE_LSB +: 2]);
  wire [1:0] dbits = ctrl_ff[CTRL_DBITS_LSB +: 2];
  wire [2:0] last_bit = {1'b1, dbits};
  wire stop_t stop = stop_t'(ctrl_ff[CTRL_STOP_LSB +: 2]);
  wire parity_t par = parity_t'(ctrl_ff[CTRL_PAR_LSB +: 3]);
  wire flow_t flow = flow_t'(ctrl_ff[CTRL_FLOW_LSB +: 2]);
  wire [7:0] dmask = 8'hFF >> (2'd3 - dbits);
  // Out-of-range divisors are clamped so software cannot leave the supported baud span.
  wire [DIV_W-1:0] div_eff = (baud_ff < DIV_MIN) ? DIV_MIN :
                             (baud_ff > DIV_MAX) ? DIV_MAX : baud_ff;
  wire [DIV_W-1:0] half_div = div_eff >> 1;
  logic [DIV_W-1:0] stop_len;
  always_comb
  begin
    unique case (stop)
      STOP_1: stop_len = div_eff;
      STOP_1P5: stop_len = div_eff + half_div;
      default: stop_len = div_eff << 1;
    endcase
  end

  function automatic logic par_bit(input logic [7:0] d, input parity_t p);
    logic r;
    r = 1'b0;
    unique case (p)
      PAR_ODD: r = ~(^d);
      PAR_EVEN: r = ^d;
      PAR_MARK: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Bus slave: one wait cycle per access, longer for a push into a full queue.
  wire full = (cnt_ff == BUF_DEPTH);
  wire acc = avs_read | avs_write;
  wire hold = avs_write && (avs_address == REG_TXDATA) && full;
  wire nxt_wait = ~(acc & wait_ff & ~hold);
  wire wr_done = avs_write & ~wait_ff;
  wire rd_done = avs_read & ~wait_ff;
  wire push = wr_done && (avs_address == REG_TXDATA);
  wire rx_pop = rd_done && (avs_address == REG_RXDATA) && avs_readdata[RX_VALID_BIT];
  wire clr_perr = wr_done && (avs_address == REG_STATUS) && avs_writedata[ST_PERR];
  wire clr_ferr = wr_done && (avs_address == REG_STATUS) && avs_writedata[ST_FERR];
  wire clr_ovr = wr_done && (avs_address == REG_STATUS) && avs_writedata[ST_OVR];
  wire [31:0] status = {23'h0, rel_ff, full, cts_s, paused_ff, tx_state_ff != T_IDLE, ovr_ff,
                        ferr_ff, perr_ff, rx_valid_ff};
  wire [31:0] rmux = (avs_address == REG_CTRL) ? {21'h0, ctrl_ff} :
                     (avs_address == REG_BAUD) ? {12'h0, baud_ff} :
                     (avs_address == REG_FLUSH) ? {16'h0, flush_ff} :
                     (avs_address == REG_TXDATA) ? {19'h0, cnt_ff} :
                     (avs_address == REG_RXDATA) ? {23'h0, rx_valid_ff, rx_data_ff} :
                     (avs_address == REG_STATUS) ? status : 32'h0000_0000;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff <= CTRL_RST;
      baud_ff <= DIV_DEF;
      flush_ff <= FLUSH_RST;
    end
    else
    begin
      wait_ff <= nxt_wait;
      if (!nxt_wait)
        rdata_ff <= rmux;
      if (wr_done && avs_address == REG_CTRL)
        ctrl_ff <= avs_writedata[10:0];
      if (wr_done && avs_address == REG_BAUD)
        baud_ff <= avs_writedata[DIV_W-1:0];
      if (wr_done && avs_address == REG_FLUSH)
        flush_ff <= avs_writedata[15:0];
    end
  end

  // Packing queue and its release timer.
  wire sw_ok = (flow != FC_SW) || !paused_ff;
  wire hw_ok = (flow == FC_RTS) ? cts_s : (flow == FC_DTR) ? dsr_s : 1'b1;
  wire ctl_req = (flow == FC_SW) && (rx_valid_ff != xoff_sent_ff);
  wire tx_idle = (tx_state_ff == T_IDLE);
  wire data_go = tx_idle && !ctl_req && rel_ff && (cnt_ff != '0) && sw_ok && hw_ok;
  wire ctl_go = tx_idle && ctl_req;
  wire timeout = (flush_ff != 16'h0) && (ms_ff >= flush_ff);
  wire ms_tick = (pre_ff == 20'(MS_CYC - 1));
  wire nxt_rel = (cnt_ff != '0) && (rel_ff || flush_ff == 16'h0 || timeout || full);

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wptr_ff] <= avs_writedata[7:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
      rel_ff <= 1'b0;
      pre_ff <= 20'h0;
      ms_ff <= 16'h0;
    end
    else
    begin
      if (push)
        wptr_ff <= wptr_ff + BUF_AW'(1);
      if (data_go)
        rptr_ff <= rptr_ff + BUF_AW'(1);
      cnt_ff <= cnt_ff + (BUF_AW+1)'(push) - (BUF_AW+1)'(data_go);
      rel_ff <= nxt_rel;
      // The idle interval restarts with every byte queued.
      pre_ff <= (push || ms_tick) ? 20'h0 : pre_ff + 20'h1;
      if (push)
        ms_ff <= 16'h0;
      else if (ms_tick && ms_ff != 16'hFFFF)
        ms_ff <= ms_ff + 16'h1;
    end
  end

  // Transmitter.
  logic tx_go, tx_done;
  logic [DIV_W-1:0] tx_len;
  tick_gen u_tx_tick (
    .mclk(mclk),
    .rstn(rstn),
    .start(tx_go),
    .len(tx_len),
    .done(tx_done)
  );
  wire [7:0] ctl_char = rx_valid_ff ? XOFF_CHAR : XON_CHAR;
  wire [7:0] load_byte = (ctl_go ? ctl_char : mem[rptr_ff]) & dmask;

  always_comb
  begin
    nxt_tx_state = tx_state_ff;
    unique case (tx_state_ff)
      T_IDLE: if (ctl_go || data_go) nxt_tx_state = T_START;
      T_START: if (tx_done) nxt_tx_state = T_DATA;
      T_DATA: if (tx_done && tbit_ff == last_bit) nxt_tx_state = (par == PAR_NONE) ? T_STOP : T_PAR;
      T_PAR: if (tx_done) nxt_tx_state = T_STOP;
      T_STOP: if (tx_done) nxt_tx_state = T_IDLE;
      default: nxt_tx_state = T_IDLE;
    endcase
    tx_go = (nxt_tx_state != tx_state_ff) && (nxt_tx_state != T_IDLE) || (tx_done && nxt_tx_state == T_DATA);
    tx_len = (nxt_tx_state == T_STOP) ? stop_len : div_eff;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      tx_state_ff <= T_IDLE;
      txd_ff <= 1'b1;
      sh_ff <= 8'h00;
      tbyte_ff <= 8'h00;
      tbit_ff <= 3'h0;
      xoff_sent_ff <= 1'b0;
    end
    else
    begin
      tx_state_ff <= nxt_tx_state;
      if (tx_idle && nxt_tx_state == T_START)
      begin
        sh_ff <= load_byte;
        tbyte_ff <= load_byte;
        tbit_ff <= 3'h0;
        txd_ff <= 1'b0;
        if (ctl_go)
          xoff_sent_ff <= rx_valid_ff;
      end
      else if (tx_done)
      begin
        unique case (nxt_tx_state)
          T_DATA:
          begin
            txd_ff <= (tx_state_ff == T_START) ? sh_ff[0] : sh_ff[1];
            if (tx_state_ff == T_DATA)
            begin
              sh_ff <= sh_ff >> 1;
              tbit_ff <= tbit_ff + 3'h1;
            end
          end
          T_PAR: txd_ff <= par_bit(tbyte_ff, par);
          default: txd_ff <= 1'b1;
        endcase
      end
    end
  end

  // Receiver; a two-wire bus hears its own echo, so it listens only while not driving.
  logic rx_go, rx_done;
  logic [DIV_W-1:0] rx_len;
  tick_gen u_rx_tick (
    .mclk(mclk),
    .rstn(rstn),
    .start(rx_go),
    .len(rx_len),
    .done(rx_done)
  );
  wire rx_allow = !(iface == IF_RS485_2W && !tx_idle);
  wire [7:0] rx_byte = rsh_ff >> (2'd3 - dbits);
  wire par_bad = (par != PAR_NONE) && (rpar_ff != par_bit(rx_byte, par));
  wire stop_bad = !rxd_s;
  wire frame_end = rx_done && (rx_state_ff == R_STOP);
  wire is_flow = (flow == FC_SW) && !par_bad && !stop_bad &&
                 (rx_byte == XOFF_CHAR || rx_byte == XON_CHAR);

  always_comb
  begin
    nxt_rx_state = rx_state_ff;
    unique case (rx_state_ff)
      R_IDLE: if (!rxd_s && rx_allow) nxt_rx_state = R_START;
      R_START: if (rx_done) nxt_rx_state = rxd_s ? R_IDLE : R_DATA;
      R_DATA: if (rx_done && rbit_ff == last_bit) nxt_rx_state = (par == PAR_NONE) ? R_STOP : R_PAR;
      R_PAR: if (rx_done) nxt_rx_state = R_STOP;
      R_STOP: if (rx_done) nxt_rx_state = R_IDLE;
      default: nxt_rx_state = R_IDLE;
    endcase
    rx_go = (rx_state_ff == R_IDLE && nxt_rx_state == R_START) || (rx_done && nxt_rx_state != R_IDLE);
    rx_len = (nxt_rx_state == R_START) ? half_div : div_eff;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rx_state_ff <= R_IDLE;
      rsh_ff <= 8'h00;
      rbit_ff <= 3'h0;
      rpar_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
      perr_ff <= 1'b0;
      ferr_ff <= 1'b0;
      ovr_ff <= 1'b0;
      paused_ff <= 1'b0;
    end
    else
    begin
      rx_state_ff <= nxt_rx_state;
      if (rx_state_ff == R_START)
        rbit_ff <= 3'h0;
      if (rx_done && rx_state_ff == R_DATA)
      begin
        rsh_ff <= {rxd_s, rsh_ff[7:1]};
        rbit_ff <= rbit_ff + 3'h1;
      end
      if (rx_done && rx_state_ff == R_PAR)
        rpar_ff <= rxd_s;
      // Hardware setting a flag wins over a software clear in the same cycle.
      perr_ff <= (frame_end && par_bad) || (perr_ff && !clr_perr);
      ferr_ff <= (frame_end && stop_bad) || (ferr_ff && !clr_ferr);
      ovr_ff <= (frame_end && !is_flow && rx_valid_ff && !rx_pop) || (ovr_ff && !clr_ovr);
      if (flow != FC_SW)
        paused_ff <= 1'b0;
      else if (frame_end && is_flow)
        paused_ff <= (rx_byte == XOFF_CHAR);
      if (frame_end && !is_flow && (!rx_valid_ff || rx_pop))
      begin
        rx_data_ff <= rx_byte;
        rx_valid_ff <= 1'b1;
      end
      else if (rx_pop)
        rx_valid_ff <= 1'b0;
    end
  end

  // Handshake and line outputs.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rts_ff <= 1'b0;
      cts_ff <= 1'b0;
      dtr_ff <= 1'b0;
      drv_ff <= 1'b1;
    end
    else
    begin
      rts_ff <= (flow == FC_RTS) && (nxt_rel || !tx_idle);
      cts_ff <= (flow == FC_RTS) && !rx_valid_ff;
      dtr_ff <= (flow == FC_DTR) && !rx_valid_ff;
      drv_ff <= (iface != IF_RS485_2W) || (nxt_tx_state != T_IDLE);
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign txd = txd_ff;
  assign rts_out = rts_ff;
  assign cts_out = cts_ff;
  assign dtr_out = dtr_ff;
  assign drv_en = drv_ff;
  assign line_mode = ctrl_ff[CTRL_IFACE_LSB +: 2];

  sequence seq_frame_open;
    tx_idle ##1 tx_state_ff == T_START;
  endsequence
  chk_start_low: assert property (@(posedge mclk) disable iff (!rstn) seq_frame_open |-> !txd_ff)
    else $error("start bit not low");
  chk_stop_high: assert property (@(posedge mclk) disable iff (!rstn)
    tx_state_ff == T_STOP && $past(tx_state_ff) != T_STOP |-> txd_ff [*2])
    else $error("stop level not high");
  chk_odd_parity: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(tx_state_ff == T_PAR) && par == PAR_ODD |-> ^{tbyte_ff, txd_ff})
    else $error("odd parity wrong");
  chk_even_parity: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(tx_state_ff == T_PAR) && par == PAR_EVEN |-> !(^{tbyte_ff, txd_ff}))
    else $error("even parity wrong");
  chk_mark_parity: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(tx_state_ff == T_PAR) && par == PAR_MARK |-> txd_ff)
    else $error("mark parity not one");
  chk_space_parity: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(tx_state_ff == T_PAR) && par == PAR_SPACE |-> !txd_ff)
    else $error("space parity not zero");
  chk_no_parity: assert property (@(posedge mclk) disable iff (!rstn)
    tx_state_ff == T_DATA && par == PAR_NONE && $stable(ctrl_ff) |=> tx_state_ff != T_PAR)
    else $error("parity slot without parity");
  chk_data_count: assert property (@(posedge mclk) disable iff (!rstn)
    tx_state_ff == T_DATA && $stable(ctrl_ff) |-> tbit_ff <= last_bit)
    else $error("too many data bits");
  chk_baud_range: assert property (@(posedge mclk) disable iff (!rstn)
    div_eff >= DIV_MIN && div_eff <= DIV_MAX)
    else $error("divisor out of range");
  chk_hw_hold: assert property (@(posedge mclk) disable iff (!rstn)
    data_go && flow == FC_RTS |-> cts_s ##1 tx_state_ff == T_START)
    else $error("sent without clear-to-send");
  chk_sw_pause: assert property (@(posedge mclk) disable iff (!rstn)
    paused_ff && flow == FC_SW |-> !data_go)
    else $error("sent while paused");
  chk_full_release: assert property (@(posedge mclk) disable iff (!rstn)
    full |=> rel_ff)
    else $error("full queue not released");
  chk_zero_interval: assert property (@(posedge mclk) disable iff (!rstn)
    flush_ff == 16'h0 && cnt_ff != '0 |=> rel_ff || cnt_ff == '0)
    else $error("zero interval held data");
endmodule
`default_nettype wire

// file: rtl/uart_pkg.sv
package uart_pkg;
  // Timing base.
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BAUD_MIN = 110;
  localparam int unsigned BAUD_MAX = 460_800;
  localparam int unsigned BAUD_DEF = 38_400;
  localparam int DIV_W = 20;
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
  localparam logic [DIV_W-1:0] DIV_DEF = DIV_W'(CLK_HZ / BAUD_DEF);
  localparam int unsigned FLUSH_UNIT_NS = 1_000_000;
  localparam int unsigned MS_CYCLES = (FLUSH_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Transmit packing buffer.
  localparam int BUF_AW = 12;
  localparam logic [BUF_AW:0] BUF_DEPTH = 13'h1000;
  // Register byte offsets.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_BAUD = 5'h04;
  localparam logic [4:0] REG_FLUSH = 5'h08;
  localparam logic [4:0] REG_TXDATA = 5'h0C;
  localparam logic [4:0] REG_RXDATA = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  // Control field positions and reset value.
  localparam int CTRL_IFACE_LSB = 0;
  localparam int CTRL_DBITS_LSB = 2;
  localparam int CTRL_STOP_LSB = 4;
  localparam int CTRL_PAR_LSB = 6;
  localparam int CTRL_FLOW_LSB = 9;
  localparam logic [10:0] CTRL_RST = 11'h00C;
  localparam logic [15:0] FLUSH_RST = 16'h0000;
  // Status bit positions, then the valid bit of the receive data word.
  localparam int ST_RXV = 0;
  localparam int ST_PERR = 1;
  localparam int ST_FERR = 2;
  localparam int ST_OVR = 3;
  localparam int ST_TXBUSY = 4;
  localparam int ST_PAUSED = 5;
  localparam int ST_CTS = 6;
  localparam int ST_FULL = 7;
  localparam int ST_REL = 8;
  localparam int RX_VALID_BIT = 8;
  // Software flow control characters.
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  localparam logic [7:0] XON_CHAR = 8'h11;

  typedef enum logic [1:0] {IF_RS232, IF_RS422, IF_RS485_2W, IF_RS485_4W} iface_t;
  typedef enum logic [1:0] {STOP_1, STOP_1P5, STOP_2} stop_t;
  typedef enum logic [2:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE} parity_t;
  typedef enum logic [1:0] {FC_NONE, FC_SW, FC_RTS, FC_DTR} flow_t;
  typedef enum logic [2:0] {T_IDLE = 3'b000, T_START = 3'b001, T_DATA = 3'b011, T_PAR = 3'b010,
                            T_STOP = 3'b110} tx_state_t;
  typedef enum logic [2:0] {R_IDLE = 3'b000, R_START = 3'b001, R_DATA = 3'b011, R_PAR = 3'b010,
                            R_STOP = 3'b110} rx_state_t;
endpackage

// file: rtl/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      meta_ff <= RST;
      sync_ff <= RST;
    end
    else
    begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// file: rtl/tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tick_gen
  import uart_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [DIV_W-1:0] len,
  output logic done
);
  logic [DIV_W-1:0] cnt_ff;
  logic run_ff;

  assign done = run_ff && (cnt_ff == '0);

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end
    else if (start)
    begin
      cnt_ff <= len - DIV_W'(1);
      run_ff <= 1'b1;
    end
    else if (done)
      run_ff <= 1'b0;
    else if (run_ff)
      cnt_ff <= cnt_ff - DIV_W'(1);
  end
endmodule
`default_nettype wire

// file: tb/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic mclk,
  input wire logic txd,
  output logic rxd,
  output logic cts_in,
  output logic dsr_in
);
  int bit_cyc = 108;
  int nbits = 8;
  int pmode = 0;
  int cyc = 0;
  logic [9:0] got_q[$];
  int t_q[$];
  initial
  begin
    rxd = 1'b1;
    cts_in = 1'b1;
    dsr_in = 1'b1;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  // Sampling is mid-bit, so a stop bit of any legal length is read once.
  always
  begin : catch
    logic [9:0] fr;
    @(negedge txd);
    t_q.push_back(cyc);
    fr = '0;
    repeat (bit_cyc / 2) @(posedge mclk);
    for (int i = 0; i < nbits + (pmode != 0) + 1; i++)
    begin
      repeat (bit_cyc) @(posedge mclk);
      fr[i] = txd;
    end
    got_q.push_back(fr);
  end
  task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
    logic [7:0] m;
    m = b & 8'((9'h001 << nbits) - 1);
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge mclk);
    for (int i = 0; i < nbits; i++)
    begin
      rxd <= m[i];
      repeat (bit_cyc) @(posedge mclk);
    end
    if (pmode != 0)
    begin
      rxd <= bad_par ^ (pmode == 1 ? ~^m : pmode == 2 ? ^m : pmode == 3);
      repeat (bit_cyc) @(posedge mclk);
    end
    rxd <= ~bad_stop;
    repeat (bit_cyc) @(posedge mclk);
    rxd <= 1'b1;
    repeat (2 * bit_cyc) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import uart_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, rxd, cts_in, dsr_in, txd, rts_out, cts_out, dtr_out, drv_en;
  logic [1:0] line_mode;
  logic [9:0] f;
  logic [7:0] d, m;
  int fails = 0;
  int checked = 0;
  int t0;
  always #10 mclk = ~mclk;
  serial_port #(.MS_CYC(20)) i_dut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd), .cts_in(cts_in),
    .dsr_in(dsr_in), .txd(txd), .rts_out(rts_out), .cts_out(cts_out), .dtr_out(dtr_out),
    .drv_en(drv_en), .line_mode(line_mode));
  serial_peer i_peer (.mclk(mclk), .txd(txd), .rxd(rxd), .cts_in(cts_in), .dsr_in(dsr_in));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // The idle edge first keeps two requests from being driven in one time step.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= wd;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20000);
    q = avs_readdata;
    if (n >= 20000) fails++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input string name, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    check(name, q, e);
  endtask
  task automatic frame(output logic [9:0] fr);
    int n;
    n = 0;
    while (i_peer.got_q.size() == 0 && n < 6000)
    begin
      @(posedge mclk);
      n++;
    end
    fr = (n < 6000) ? i_peer.got_q.pop_front() : '1;
    if (n >= 6000) fails++;
  endtask
  task automatic cfg(input int nb, input int pm, input int st, input int fc, input int ifc);
    i_peer.nbits = nb;
    i_peer.pmode = pm;
    bus(1'b1, REG_CTRL, 32'(fc << 9 | pm << 6 | st << 4 | (nb - 5) << 2 | ifc));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    // About half as long again as the expected run, and still inside the cycle budget.
    #1_900_000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    check("txd idle", txd, 1);
    rd("ctrl", REG_CTRL, 32'(CTRL_RST));
    rd("baud", REG_BAUD, 32'(DIV_DEF));
    rd("flush", REG_FLUSH, 32'(FLUSH_RST));
    rd("unmapped", 5'h18, 32'h0000_0000);
    bus(1'b1, REG_BAUD, 32'h0000_000A);
    rd("baud raw", REG_BAUD, 32'h0000_000A);
    for (int i = 3; i >= 0; i--)
    begin
      cfg(8, 0, 0, 0, i);
      repeat (3) @(negedge mclk);
      check("line_mode", line_mode, 32'(i));
      check("drv_en", drv_en, i != 2);
    end
    cfg(8, 0, 0, 0, 2);
    bus(1'b1, REG_TXDATA, 32'h0000_0011);
    @(negedge txd);
    @(negedge mclk);
    check("drv_en frame", drv_en, 1);
    frame(f);
    check("frame 2w", f[7:0], 8'h11);
    for (int nb = 5; nb <= 8; nb++)
      for (int pm = 0; pm <= 4; pm++)
      begin
        cfg(nb, pm, 0, 0, 0);
        d = 8'h96 ^ 8'(nb * 5 + pm);
        bus(1'b1, REG_TXDATA, 32'(d));
        frame(f);
        m = d & 8'((9'h001 << nb) - 1);
        check("data", f & 10'((11'h001 << nb) - 1), m);
        check("stop", f[nb + (pm != 0)], 1);
        if (pm != 0)
          check("parity", f[nb], pm == 1 ? ~^m : pm == 2 ? ^m : pm == 3);
      end
    for (int st = 0; st <= 2; st++)
    begin
      cfg(8, 0, st, 0, 0);
      i_peer.t_q.delete();
      bus(1'b1, REG_TXDATA, 32'h0000_0055);
      bus(1'b1, REG_TXDATA, 32'h0000_00AA);
      frame(f);
      frame(f);
      t0 = i_peer.t_q[1] - i_peer.t_q[0] - 9 * 108 - 108 * (st + 2) / 2;
      check("stop span", t0 >= 0 && t0 <= 3, 1);
    end
    cfg(8, 2, 0, 0, 0);
    i_peer.send(8'h5A, 1'b0, 1'b0);
    rd("rx data", REG_RXDATA, 32'h0000_015A);
    i_peer.send(8'h5A, 1'b1, 1'b1);
    bus(1'b0, REG_STATUS, '0);
    check("rx errors", q[2:1], 2'h3);
    bus(1'b0, REG_RXDATA, '0);
    bus(1'b1, REG_STATUS, 32'h0000_000E);
    cfg(5, 0, 0, 0, 0);
    i_peer.send(8'hE9, 1'b0, 1'b0);
    bus(1'b0, REG_STATUS, '0);
    check("no parity check", q[2:1], 2'h0);
    rd("rx five bits", REG_RXDATA, 32'h0000_0109);
    cfg(8, 0, 0, 1, 0);
    i_peer.send(XOFF_CHAR, 1'b0, 1'b0);
    bus(1'b0, REG_STATUS, '0);
    check("paused", q[ST_PAUSED], 1);
    bus(1'b1, REG_TXDATA, 32'h0000_0042);
    repeat (3000) @(posedge mclk);
    check("held", i_peer.got_q.size(), 0);
    i_peer.send(XON_CHAR, 1'b0, 1'b0);
    frame(f);
    check("resumed", f[7:0], 8'h42);
    i_peer.send(8'h33, 1'b0, 1'b0);
    frame(f);
    check("pause sent", f[7:0], XOFF_CHAR);
    bus(1'b0, REG_RXDATA, '0);
    frame(f);
    check("resume sent", f[7:0], XON_CHAR);
    for (int fc = 2; fc <= 3; fc++)
    begin
      i_peer.cts_in <= (fc != 2);
      i_peer.dsr_in <= (fc != 3);
      cfg(8, 0, 0, fc, 0);
      bus(1'b1, REG_TXDATA, 32'h0000_0077);
      repeat (3000) @(posedge mclk);
      check("gated", i_peer.got_q.size(), 0);
      check("request", rts_out, fc == 2);
      check("ready", fc == 2 ? cts_out : dtr_out, 1);
      i_peer.cts_in <= 1'b1;
      i_peer.dsr_in <= 1'b1;
      frame(f);
      check("sent", f[7:0], 8'h77);
      i_peer.send(8'h01, 1'b0, 1'b0);
      check("not ready", fc == 2 ? cts_out : dtr_out, 0);
      bus(1'b0, REG_RXDATA, '0);
    end
    cfg(8, 0, 0, 0, 0);
    bus(1'b1, REG_FLUSH, 32'h0000_0002);
    bus(1'b1, REG_TXDATA, 32'h0000_0024);
    t0 = i_peer.cyc;
    rd("queued", REG_TXDATA, 32'h0000_0001);
    i_peer.t_q.delete();
    frame(f);
    t0 = i_peer.t_q[0] - t0;
    check("flush wait", t0 >= 39 && t0 <= 45, 1);
    bus(1'b1, REG_FLUSH, 32'h0000_FFFF);
    i_peer.t_q.delete();
    for (int i = 0; i < 4095; i++)
      bus(1'b1, REG_TXDATA, 32'(i));
    rd("queue 4095", REG_TXDATA, 32'h0000_0FFF);
    check("no release", i_peer.t_q.size(), 0);
    bus(1'b1, REG_TXDATA, 32'h0000_0000);
    frame(f);
    check("full release", f[7:0], 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
